/* nfseq_pkg.sv */
`default_nettype none
package nfseq_pkg;
	localparam logic [7:0] CMD_READ     = 8'h00;
	localparam logic [7:0] CMD_READ_GO  = 8'h30;
	localparam logic [7:0] CMD_SERIAL   = 8'h80;
	localparam logic [7:0] CMD_PROGRAM  = 8'h10;
	localparam logic [7:0] CMD_ERASE1   = 8'h60;
	localparam logic [7:0] CMD_ERASE2   = 8'hd0;
	localparam logic [7:0] CMD_STATUS   = 8'h70;
	localparam logic [7:0] CMD_RESET    = 8'hff;
	localparam int         FAIL_BIT     = 0;
	localparam int         READY_BIT    = 6;
	localparam logic [7:0] BAD_MARK     = 8'h00;
	localparam int         COL_CYCLES   = 2;
	localparam int         ROW_CYCLES   = 3;
	localparam int         CLK_MHZ      = 20;
	localparam int         T_STROBE_NS  = 100;
	localparam int         STROBE_CYC   = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int         PAGE_BITS    = 6;
	localparam int         BLOCK_BITS   = 11;
	localparam logic [3:0] OP_NONE      = 4'h0;
	localparam logic [3:0] OP_READ      = 4'h1;
	localparam logic [3:0] OP_PROGRAM   = 4'h2;
	localparam logic [3:0] OP_ERASE     = 4'h3;
	localparam logic [3:0] OP_BADCHECK  = 4'h4;
	localparam logic [1:0] RES_PASS     = 2'h0;
	localparam logic [1:0] RES_FAIL     = 2'h1;
	localparam logic [1:0] RES_BAD      = 2'h2;
	localparam logic [1:0] RES_REFUSED  = 2'h3;
endpackage
`default_nettype wire

/* nfseq_cyc_if.sv */
`default_nettype none
interface nfseq_cyc_if;
	logic       start;
	logic [1:0] kind;
	logic [7:0] wdata;
	logic       done;
	logic [7:0] rdata;
	modport ctl (output start, output kind, output wdata, input done, input rdata);
	modport cyc (input start, input kind, input wdata, output done, output rdata);
endinterface
`default_nettype wire

/* nfseq_cycle.sv */
`default_nettype none
// One bus cycle: kind 0 command, 1 address, 2 data write, 3 data read
module nfseq_cycle (
	input  wire logic  clk,        // Clock
	input  wire logic  rst_n,      // Async reset
	input  wire logic  ce,         // Clock enable
	nfseq_cyc_if.cyc   bus,        // Cycle request
	input  wire logic [7:0] io_in, // Pin data in
	output logic [7:0] io_out,     // Pin data out
	output logic       io_oe,      // Pin drive
	output logic       cle,        // Command latch
	output logic       ale,        // Address latch
	output logic       we_n,       // Write strobe
	output logic       re_n        // Read strobe
);
	// Counter must hold a full low-plus-high period without wrapping
	localparam int CW = $clog2(2 * nfseq_pkg::STROBE_CYC + 1);
	logic [CW-1:0] cnt, next_cnt;
	logic          busy, next_busy;
	logic [1:0]    kind, next_kind;
	logic [7:0]    rd, next_rd;
	logic [7:0]    wd, next_wd;
	logic          dn, next_dn;
	always_comb begin
		next_cnt  = cnt;
		next_busy = busy;
		next_kind = kind;
		next_rd   = rd;
		next_wd   = wd;
		next_dn   = 1'b0;
		if (!busy && bus.start) begin
			next_busy = 1'b1;
			next_kind = bus.kind;
			next_wd   = bus.wdata;
			next_cnt  = CW'(2 * nfseq_pkg::STROBE_CYC);
		end else if (busy) begin
			if (cnt == CW'(nfseq_pkg::STROBE_CYC) && kind == 2'd3)
				next_rd = io_in;
			if (cnt == '0) begin
				next_busy = 1'b0;
				next_dn   = 1'b1;
			end else
				next_cnt = cnt - CW'(1);
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= '0; busy <= 1'b0; kind <= 2'd0;
			rd <= 8'h00; wd <= 8'h00; dn <= 1'b0;
		end else if (ce) begin
			cnt <= next_cnt; busy <= next_busy; kind <= next_kind;
			rd <= next_rd; wd <= next_wd; dn <= next_dn;
		end
	end
	// Strobe low for the first STROBE_CYC cycles, high for the last STROBE_CYC + 1, data held over both
	wire strobe = busy && cnt > CW'(nfseq_pkg::STROBE_CYC);
	assign we_n   = !(strobe && kind != 2'd3);
	assign re_n   = !(strobe && kind == 2'd3);
	assign cle    = busy && kind == 2'd0;
	assign ale    = busy && kind == 2'd1;
	assign io_oe  = busy && kind != 2'd3;
	assign io_out = wd;
	assign bus.done  = dn;
	assign bus.rdata = rd;
endmodule
`default_nettype wire

/* nfseq_host.sv */
`default_nettype none
// Overview of operation
// - During initialization host issues only reset or status read.
// - While busy host sends only status read or reset commands.
// - After serial input host follows only with program or reset.
// - Host refuses program requests that skip or repeat a page in a block.
// - Host issues only defined command codes.
// - Bad block check reads one column; zero byte marks block bad.
// - Host refuses to erase a block found bad.
// - After program failure host reports fail and marks block bad.
// - Host correction must cover eight bit errors per 512 bytes; this host returns raw bytes with no correction.
// - Block management tolerates 2008 good blocks of 2048.
module nfseq_host #(
	parameter int BLOCKS = 2048    // Block count
) (
	input  wire logic        CLOCK,      // 20 MHz clock
	input  wire logic        RESETN,     // Async reset, active low
	input  wire logic        CE,         // Clock enable
	input  wire logic        REQ,        // Operation request pulse
	input  wire logic [3:0]  OP,         // Operation code
	input  wire logic [16:0] ROW,        // Block and page
	input  wire logic [11:0] COLUMN,     // Column
	input  wire logic [7:0]  WDATA,      // Program byte
	input  wire logic        WP_OFF,     // Allow program and erase
	output logic             ACK,        // Operation finished pulse
	output logic [1:0]       RESULT,     // Outcome code
	output logic [7:0]       RDATA,      // Read byte
	output logic             IDLE,       // Ready for request
	input  wire logic [7:0]  IO_IN,      // Flash I/O in
	output logic [7:0]       IO_OUT,     // Flash I/O out
	output logic             IO_OE,      // Flash I/O drive
	output logic             CLE,        // Command latch enable
	output logic             ALE,        // Address latch enable
	output logic             WE_N,       // Write strobe
	output logic             READ_STROBE_N, // Read strobe
	output logic             WP_N,       // Write protect
	input  wire logic        READY_BUSY_N_PIN // Ready/busy from flash
);
	typedef enum {S_INIT, S_INITWAIT, S_IDLE, S_CMD, S_ADDR, S_DATA, S_CMD2, S_BUSY,
		S_STAT, S_STATRD, S_RDCMD, S_RDDATA, S_DONE} nfseq_state_t;
	// Cycle engine owns strobe timing; this machine only orders the bytes
	nfseq_cyc_if cy ();
	logic [7:0] c_io;
	logic       c_oe, c_cle, c_ale, c_we, c_re;
	nfseq_cycle u_cyc (
		.clk(CLOCK), .rst_n(RESETN), .ce(CE), .bus(cy),
		.io_in(IO_IN), .io_out(c_io), .io_oe(c_oe),
		.cle(c_cle), .ale(c_ale), .we_n(c_we), .re_n(c_re)
	);

	nfseq_state_t st, next_st;
	logic [3:0]   op, next_op;
	logic [16:0]  row, next_row;
	logic [11:0]  col, next_col;
	logic [7:0]   wd, next_wd;
	logic [2:0]   ai, next_ai;
	logic         go, next_go;
	logic [1:0]   knd, next_knd;
	logic [7:0]   cb, next_cb;
	logic [1:0]   res, next_res;
	logic [7:0]   rdat, next_rdat;
	logic         ack, next_ack;
	// Ready trusted only once the busy state has seen the last strobe end
	logic         rdy_s;
	logic [BLOCKS-1:0]  bad, next_bad; // Any number of blocks may retire
	// No reset on the page table; erase a block before its first program
	logic [nfseq_pkg::PAGE_BITS:0] last_pg [BLOCKS];
	logic         pg_we;
	wire [nfseq_pkg::BLOCK_BITS-1:0] blk = row[16:nfseq_pkg::PAGE_BITS];
	wire [nfseq_pkg::PAGE_BITS-1:0]  pg  = row[nfseq_pkg::PAGE_BITS-1:0];

	// Column bytes first, then three row bytes, the top one a single bit
	function automatic logic [7:0] addr_byte(input logic [2:0] i, input logic [11:0] c,
			input logic [16:0] r);
		case (i)
			3'd0: addr_byte = c[7:0];
			3'd1: addr_byte = {4'h0, c[11:8]};
			3'd2: addr_byte = r[7:0];
			3'd3: addr_byte = r[15:8];
			default: addr_byte = {7'h00, r[16]};
		endcase
	endfunction

	// Page order tracker: stored value is last page + 1, zero after erase
	always_ff @(posedge CLOCK) begin
		if (CE && pg_we)
			last_pg[blk] <= (op == nfseq_pkg::OP_ERASE) ? '0 : {1'b0, pg} + 1'b1;
	end

	always_comb begin
		next_st = st; next_op = op; next_row = row; next_col = col; next_wd = wd;
		next_ai = ai; next_go = 1'b0; next_knd = knd; next_cb = cb; next_res = res;
		next_rdat = rdat; next_ack = 1'b0; next_bad = bad; pg_we = 1'b0;
		case (st)
			S_INIT: begin
				// Reset first, so nothing else goes out while initializing
				next_cb = nfseq_pkg::CMD_RESET; next_knd = 2'd0; next_go = 1'b1;
				next_st = S_INITWAIT;
			end
			S_INITWAIT: if (cy.done) next_st = S_BUSY;
			S_IDLE: if (REQ) begin
				next_op = OP; next_row = ROW; next_col = COLUMN; next_wd = WDATA;
				next_ai = 3'd0;
				next_res = nfseq_pkg::RES_PASS;
				// Refusals finish without touching the pins
				if (OP == nfseq_pkg::OP_ERASE && bad[ROW[16:nfseq_pkg::PAGE_BITS]])
					begin next_res = nfseq_pkg::RES_REFUSED; next_st = S_DONE; end
				// Only the next page in order; a skipped page can never be filled later
				else if (OP == nfseq_pkg::OP_PROGRAM && (bad[ROW[16:nfseq_pkg::PAGE_BITS]]
						|| {1'b0, ROW[nfseq_pkg::PAGE_BITS-1:0]}
						!= last_pg[ROW[16:nfseq_pkg::PAGE_BITS]]))
					begin next_res = nfseq_pkg::RES_REFUSED; next_st = S_DONE; end
				else if (OP == nfseq_pkg::OP_READ || OP == nfseq_pkg::OP_BADCHECK
						|| OP == nfseq_pkg::OP_PROGRAM || OP == nfseq_pkg::OP_ERASE) begin
					next_cb = (OP == nfseq_pkg::OP_PROGRAM) ? nfseq_pkg::CMD_SERIAL :
						(OP == nfseq_pkg::OP_ERASE) ? nfseq_pkg::CMD_ERASE1 :
						nfseq_pkg::CMD_READ;
					next_knd = 2'd0; next_go = 1'b1; next_st = S_CMD;
				end else begin
					next_res = nfseq_pkg::RES_REFUSED; next_st = S_DONE;
				end
			end
			S_CMD: if (cy.done) begin
				next_ai = (op == nfseq_pkg::OP_ERASE) ? 3'(nfseq_pkg::COL_CYCLES) : 3'd0;
				next_cb = addr_byte(next_ai, col, row); next_knd = 2'd1; next_go = 1'b1;
				next_st = S_ADDR;
			end
			S_ADDR: if (cy.done) begin
				// Stop at the fifth address byte (three cycles for erase), never a sixth
				if (ai == 3'(nfseq_pkg::COL_CYCLES + nfseq_pkg::ROW_CYCLES - 1)) begin
					next_knd = (op == nfseq_pkg::OP_PROGRAM) ? 2'd2 : 2'd0;
					next_cb = (op == nfseq_pkg::OP_PROGRAM) ? wd :
						(op == nfseq_pkg::OP_ERASE) ? nfseq_pkg::CMD_ERASE2 :
						nfseq_pkg::CMD_READ_GO;
					next_go = 1'b1;
					next_st = (op == nfseq_pkg::OP_PROGRAM) ? S_DATA : S_CMD2;
				end else begin
					next_ai = ai + 3'd1;
					next_cb = addr_byte(ai + 3'd1, col, row); next_go = 1'b1;
				end
			end
			S_DATA: if (cy.done) begin
				// Only the program confirm may follow serial input
				next_cb = nfseq_pkg::CMD_PROGRAM; next_knd = 2'd0; next_go = 1'b1;
				next_st = S_CMD2;
			end
			S_CMD2: if (cy.done) next_st = S_BUSY;
			// No timeout: a ready pin stuck low leaves the machine waiting here
			S_BUSY: if (rdy_s) begin
				next_cb = nfseq_pkg::CMD_STATUS; next_knd = 2'd0; next_go = 1'b1;
				next_st = S_STAT;
			end
			S_STAT: if (cy.done) begin
				next_knd = 2'd3; next_go = 1'b1; next_st = S_STATRD;
			end
			S_STATRD: if (cy.done) begin
				if (op == nfseq_pkg::OP_NONE) next_st = S_IDLE;
				else if (op == nfseq_pkg::OP_PROGRAM || op == nfseq_pkg::OP_ERASE) begin
					if (cy.rdata[nfseq_pkg::FAIL_BIT]) begin
						next_res = nfseq_pkg::RES_FAIL;
						// Block retired; caller rewrites the data elsewhere
						next_bad[blk] = 1'b1;
					end else
						pg_we = 1'b1;
					next_st = S_DONE;
				end else begin
					// Status mode sticks; read command resumes data at column
					next_cb = nfseq_pkg::CMD_READ; next_knd = 2'd0; next_go = 1'b1;
					next_st = S_RDCMD;
				end
			end
			S_RDCMD: if (cy.done) begin
				next_knd = 2'd3; next_go = 1'b1; next_st = S_RDDATA;
			end
			S_RDDATA: if (cy.done) begin
				next_rdat = cy.rdata; // Raw byte, error correction left to the consumer
				if (op == nfseq_pkg::OP_BADCHECK && cy.rdata == nfseq_pkg::BAD_MARK) begin
					next_res = nfseq_pkg::RES_BAD; next_bad[blk] = 1'b1;
				end
				next_st = S_DONE;
			end
			S_DONE: begin
				next_ack = 1'b1; next_st = S_IDLE;
			end
			default: next_st = S_INIT;
		endcase
	end

	assign cy.start = go;
	assign cy.kind  = knd;
	assign cy.wdata = cb;

	// Pins pass one more flop so every output leaves a register
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			st <= S_INIT; op <= nfseq_pkg::OP_NONE; row <= '0; col <= '0; wd <= 8'h00;
			ai <= 3'd0; go <= 1'b0; knd <= 2'd0; cb <= 8'h00; res <= nfseq_pkg::RES_PASS;
			rdat <= 8'h00; ack <= 1'b0; bad <= '0; rdy_s <= 1'b0;
			IO_OUT <= 8'h00; IO_OE <= 1'b0; CLE <= 1'b0; ALE <= 1'b0; WE_N <= 1'b1;
			READ_STROBE_N <= 1'b1; WP_N <= 1'b0; ACK <= 1'b0; RESULT <= 2'd0;
			RDATA <= 8'h00; IDLE <= 1'b0;
		end else if (CE) begin
			st <= next_st; op <= next_op; row <= next_row; col <= next_col; wd <= next_wd;
			ai <= next_ai; go <= next_go; knd <= next_knd; cb <= next_cb; res <= next_res;
			rdat <= next_rdat; ack <= next_ack; bad <= next_bad;
			rdy_s <= READY_BUSY_N_PIN && !go && st == S_BUSY;
			IO_OUT <= c_io; IO_OE <= c_oe; CLE <= c_cle; ALE <= c_ale; WE_N <= c_we;
			READ_STROBE_N <= c_re;
			WP_N <= WP_OFF;
			ACK <= next_ack; RESULT <= next_res; RDATA <= next_rdat;
			IDLE <= next_st == S_IDLE;
		end
	end
endmodule
`default_nettype wire

/* nfseq_sva.sv */
`default_nettype none
module nfseq_sva (
	input wire logic       CLOCK,            // Clock
	input wire logic       RESETN,           // Reset
	input wire logic       CE,               // Enable
	input wire logic       REQ,              // Request
	input wire logic [3:0] OP,               // Operation
	input wire logic       IDLE,             // Ready
	input wire logic       ACK,              // Done
	input wire logic [1:0] RESULT,           // Outcome
	input wire logic [7:0] IO_OUT,           // Bus out
	input wire logic       CLE,              // Command latch
	input wire logic       ALE,              // Address latch
	input wire logic       WE_N,             // Write strobe
	input wire logic       WP_N,             // Protect
	input wire logic       WP_OFF,           // Protect off
	input wire logic       READY_BUSY_N_PIN  // Ready
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RESETN);
	logic       we_q;
	logic       rb_q;
	logic       init;
	logic [7:0] last;
	logic [2:0] addr_n;
	wire        latch = WE_N && !we_q;
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			we_q <= 1'b1;
			rb_q <= 1'b0;
			init <= 1'b1;
			last <= 8'hff;
			addr_n <= 3'h0;
		end else begin
			we_q <= WE_N;
			rb_q <= READY_BUSY_N_PIN;
			if (READY_BUSY_N_PIN)
				init <= 1'b0;
			if (latch && CLE)
				last <= IO_OUT;
			if (latch && CLE)
				addr_n <= 3'h0;
			else if (latch && ALE && addr_n != 3'h7)
				addr_n <= addr_n + 3'h1;
		end
	end
	sequence s_cmd;
		latch && CLE;
	endsequence
	sequence s_bad_req;
		REQ && IDLE && CE && !(OP inside {4'h1, 4'h2, 4'h3, 4'h4});
	endsequence
	property p_defined;
		s_cmd |-> IO_OUT inside {8'h00, 8'h30, 8'h80, 8'h10, 8'h60, 8'hd0, 8'h70, 8'hff};
	endproperty
	property p_init;
		s_cmd ##0 init |-> IO_OUT inside {8'hff, 8'h70};
	endproperty
	// Ready as it stood at the latching edge, before the device reacts
	property p_busy;
		s_cmd ##0 !rb_q |-> IO_OUT inside {8'h70, 8'hff};
	endproperty
	property p_serial;
		s_cmd ##0 (last == 8'h80) |-> IO_OUT inside {8'h85, 8'h10, 8'h11, 8'h15, 8'hff};
	endproperty
	property p_poll;
		s_cmd ##0 (last inside {8'h10, 8'hd0}) |-> IO_OUT inside {8'h70, 8'hff};
	endproperty
	property p_addr;
		addr_n <= 3'h5;
	endproperty
	property p_refuse;
		s_bad_req |-> ##2 ACK && RESULT == 2'h3;
	endproperty
	property p_quiet;
		s_bad_req |=> (WE_N && !CLE && !ALE)[*3];
	endproperty
	property p_wp;
		CE && !WP_OFF |=> !WP_N;
	endproperty
	a_defined: assert property (p_defined) else $error("undefined command code");
	a_init: assert property (p_init) else $error("command during power-up");
	a_busy: assert property (p_busy) else $error("command while busy");
	a_serial: assert property (p_serial) else $error("bad command after serial in");
	a_poll: assert property (p_poll) else $error("no status poll");
	a_addr: assert property (p_addr) else $error("too many address cycles");
	a_refuse: assert property (p_refuse) else $error("unknown op not refused");
	a_quiet: assert property (p_quiet) else $error("pins moved on refusal");
	a_wp: assert property (p_wp) else $error("protect not driven");
endmodule
bind nfseq_host nfseq_sva u_sva (.CLOCK(CLOCK), .RESETN(RESETN), .CE(CE), .REQ(REQ),
	.OP(OP), .IDLE(IDLE), .ACK(ACK), .RESULT(RESULT), .IO_OUT(IO_OUT), .CLE(CLE),
	.ALE(ALE), .WE_N(WE_N), .WP_N(WP_N), .WP_OFF(WP_OFF),
	.READY_BUSY_N_PIN(READY_BUSY_N_PIN));
`default_nettype wire

/* nfseq_flash_model.sv */
`default_nettype none
module nfseq_flash_model #(
	parameter int BAD_BLK  = 5,  // Factory-marked block
	parameter int FAIL_BLK = 7   // Programs here fail
) (
	input  wire logic       we_n,  // Write strobe
	input  wire logic       re_n,  // Read strobe
	input  wire logic       cle,   // Command latch
	input  wire logic       ale,   // Address latch
	input  wire logic       wp_n,  // Protect
	input  wire logic [7:0] din,   // Bus level
	output logic      [7:0] dout,  // Driven data
	output logic            rb_n   // Ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0]  mem [int];
	logic [7:0]  a [5];
	logic [7:0]  wd;
	logic [16:0] row;
	logic [11:0] col;
	logic        smode;
	logic        pend;
	logic        fail;
	int          na;
	assign row = {a[4][0], a[3], a[2]};
	// Blocks the latch process; host must not strobe while busy anyway
	localparam int INIT_NS = 2000; // Power-up busy time
	task automatic go(input int t);
		rb_n = 1'b0;
		for (int i = 0; i < t && wp_n; i++)
			#50;
		if (!wp_n)
			fail = 1'b1;
		// Initialization busy outlasts an early reset command
		if ($time >= INIT_NS)
			rb_n = 1'b1;
	endtask
	initial begin
		{rb_n, smode, pend, fail, na, dout} = '0;
		#INIT_NS rb_n = 1'b1;
	end
	always @(posedge we_n) begin
		if (cle) begin
			if (din != 8'h10)
				pend = 1'b0;
			case (din)
			8'hff: begin
				smode = 1'b0;
				fail = 1'b0;
				go(5);
			end
			8'h70: smode = 1'b1;
			8'h00: begin
				smode = 1'b0;
				na = 0;
			end
			8'h80: begin
				pend = 1'b1;
				na = 0;
			end
			8'h60: na = 2; // Erase sends row bytes only
			8'h30: begin
				col = {a[1][3:0], a[0]};
				go(20);
			end
			8'h10: if (pend) begin
				pend = 1'b0;
				fail = !wp_n || row[16:6] == FAIL_BLK;
				if (!fail)
					mem[int'({row, a[1][3:0], a[0]})] = wd;
				go(60);
			end
			8'hd0: begin
				fail = !wp_n;
				go(100);
			end
			default: ;
			endcase
		end else if (ale) begin
			if (na < 5)
				a[na] = din;
			na++;
		end else if (pend)
			wd = din;
	end
	always @(negedge re_n) begin
		if (smode)
			dout = {wp_n, rb_n, rb_n, 4'h0, fail};
		else begin
			if (row[16:6] == BAD_BLK)
				dout = 8'h00;
			else if (mem.exists(int'({row, col})))
				dout = mem[int'({row, col})];
			else
				dout = 8'h80 | {1'b0, col[6:0]};
			col++;
		end
	end
	// Released bus must not keep showing the last byte
	always @(posedge re_n)
		#20 dout = ~dout;
endmodule
`default_nettype wire

/* nfseq_host_tb.sv */
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
	$display("mismatch %0t %h %h", $time, a, b); end end
module nfseq_host_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLOCK, RESETN, CE, REQ, WP_OFF, ACK, IDLE, IO_OE, CLE, ALE, WE_N;
	logic READ_STROBE_N, WP_N, READY_BUSY_N_PIN;
	logic [3:0]  OP;
	logic [16:0] ROW;
	logic [11:0] COLUMN;
	logic [7:0]  WDATA, RDATA, IO_IN, IO_OUT, mdout;
	logic [1:0]  RESULT;
	int          bad_count, checks;
	assign IO_IN = IO_OE ? IO_OUT : mdout;
	nfseq_host #(.BLOCKS(2048)) dut (
		.CLOCK(CLOCK), .RESETN(RESETN), .CE(CE), .REQ(REQ), .OP(OP), .ROW(ROW),
		.COLUMN(COLUMN), .WDATA(WDATA), .WP_OFF(WP_OFF), .ACK(ACK), .RESULT(RESULT),
		.RDATA(RDATA), .IDLE(IDLE), .IO_IN(IO_IN), .IO_OUT(IO_OUT), .IO_OE(IO_OE),
		.CLE(CLE), .ALE(ALE), .WE_N(WE_N), .READ_STROBE_N(READ_STROBE_N), .WP_N(WP_N),
		.READY_BUSY_N_PIN(READY_BUSY_N_PIN));
	nfseq_flash_model model (.we_n(WE_N), .re_n(READ_STROBE_N), .cle(CLE), .ale(ALE),
		.wp_n(WP_N), .din(IO_IN), .dout(mdout), .rb_n(READY_BUSY_N_PIN));
	task report_and_stop;
		if (bad_count == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task run(input logic [3:0] op, input logic [16:0] row, input logic [11:0] col,
		input logic [7:0] wd);
		int n;
		n = 0;
		while (IDLE !== 1'b1 && n < 20000) begin
			@(negedge CLOCK);
			n++;
		end
		{OP, ROW, COLUMN, WDATA, REQ} = {op, row, col, wd, 1'b1};
		@(negedge CLOCK);
		REQ = 1'b0;
		while (ACK !== 1'b1 && n < 20000) begin
			@(negedge CLOCK);
			n++;
		end
		if (n >= 20000) begin
			bad_count++;
			report_and_stop;
		end
	endtask
	task t_refuse;
		run(4'h7, 17'h0, 12'h0, 8'h0);
		`CHK(RESULT, nfseq_pkg::RES_REFUSED)
		run(4'h0, 17'h0, 12'h0, 8'h0);
		`CHK(RESULT, nfseq_pkg::RES_REFUSED)
	endtask
	task t_order;
		run(nfseq_pkg::OP_ERASE, {11'd1, 6'd0}, 12'h0, 8'h0);
		`CHK(RESULT, nfseq_pkg::RES_PASS)
		run(nfseq_pkg::OP_PROGRAM, {11'd1, 6'd0}, 12'h010, 8'ha5);
		`CHK(RESULT, nfseq_pkg::RES_PASS)
		run(nfseq_pkg::OP_PROGRAM, {11'd1, 6'd2}, 12'h010, 8'h3c);
		`CHK(RESULT, nfseq_pkg::RES_REFUSED)
		run(nfseq_pkg::OP_PROGRAM, {11'd1, 6'd1}, 12'h011, 8'h3c);
		`CHK(RESULT, nfseq_pkg::RES_PASS)
	endtask
	task t_read;
		run(nfseq_pkg::OP_READ, {11'd1, 6'd0}, 12'h010, 8'h0);
		`CHK(RDATA, 8'ha5)
		`CHK(RESULT, nfseq_pkg::RES_PASS)
	endtask
	task t_bad;
		run(nfseq_pkg::OP_BADCHECK, {11'd5, 6'd0}, 12'h0, 8'h0);
		`CHK(RESULT, nfseq_pkg::RES_BAD)
		run(nfseq_pkg::OP_ERASE, {11'd5, 6'd0}, 12'h0, 8'h0);
		`CHK(RESULT, nfseq_pkg::RES_REFUSED)
		run(nfseq_pkg::OP_BADCHECK, {11'd2, 6'd0}, 12'h0, 8'h0);
		`CHK(RESULT, nfseq_pkg::RES_PASS)
	endtask
	task t_fail;
		run(nfseq_pkg::OP_ERASE, {11'd7, 6'd0}, 12'h0, 8'h0);
		`CHK(RESULT, nfseq_pkg::RES_PASS)
		run(nfseq_pkg::OP_PROGRAM, {11'd7, 6'd0}, 12'h0, 8'h11);
		`CHK(RESULT, nfseq_pkg::RES_FAIL)
		run(nfseq_pkg::OP_PROGRAM, {11'd7, 6'd1}, 12'h0, 8'h11);
		`CHK(RESULT, nfseq_pkg::RES_REFUSED)
	endtask
	task t_wp;
		WP_OFF = 1'b0;
		run(nfseq_pkg::OP_PROGRAM, {11'd1, 6'd2}, 12'h0, 8'h22);
		`CHK(RESULT, nfseq_pkg::RES_FAIL)
		WP_OFF = 1'b1;
	endtask
	initial begin
		CLOCK = 1'b0;
		forever #25 CLOCK = ~CLOCK;
	end
	initial begin
		{RESETN, REQ, OP, ROW, COLUMN, WDATA, bad_count, checks} = '0;
		{CE, WP_OFF} = 2'b11;
		repeat (10) @(negedge CLOCK);
		`CHK(WE_N, 1'b1)
		`CHK(READ_STROBE_N, 1'b1)
		`CHK(IO_OE, 1'b0)
		`CHK(IDLE, 1'b0)
		`CHK(ACK, 1'b0)
		`CHK(WP_N, 1'b0)
		RESETN = 1'b1;
		t_refuse;
		t_order;
		t_read;
		t_bad;
		t_fail;
		t_wp;
		report_and_stop;
	end
endmodule
`default_nettype wire
